//--- hdl/sram_port_pkg.sv
package sram_port_pkg;

   // ----------------------------------------------------------------
   // Geometry of the memory array
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;  // Word address width of the modelled array.
   localparam int LANES = 4;  // Number of byte lanes in a word.
   localparam int DATA_W = 32;  // Data width, eight bits per lane.
   localparam int BURST_W = 2;  // Width of the burst counter.
   localparam int DEPTH = 256;  // Words held by the array.
   localparam logic [1:0] BURST_STEP = 2'h1;  // Increment of the burst counter.
   localparam logic [1:0] BURST_ZERO = 2'h0;  // Burst counter after a strobe.

   // ----------------------------------------------------------------
   // Bus-side signal groups
   // ----------------------------------------------------------------

   // Chip enables, as seen at the pins.
   typedef struct packed {
      logic pipe_n;  // Address-pipelining enable, active low.
      logic depth_hi;  // Depth-expansion enable, active high.
      logic depth_n;  // Depth-expansion enable, active low.
   } chip_sel_t;

   // Write controls, as seen at the pins.
   typedef struct packed {
      logic global_n;  // Global write, active low.
      logic byte_en_n;  // Byte write enable, active low.
      logic [LANES-1:0] lane_n;  // Per-lane write selects, active low.
   } write_ctl_t;

   // Operating states of the port.
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,  // Deselected or after reset.
      ST_READ = 3'h2,  // Read burst in progress, bus driven.
      ST_WRITE = 3'h4  // Write burst in progress, bus floated.
   } port_state_t;

   // Whole registered state of the port.
   typedef struct packed {
      port_state_t state;  // Current operating state.
      logic [ADDR_W-1:0] base;  // Address caught by the last strobe.
      logic [BURST_W-1:0] cnt;  // Burst offset.
      logic first;  // High in the cycle after a processor strobe.
      logic drive;  // Read data bus driven.
      logic [DATA_W-1:0] q;  // Read data to the pins.
      logic in_sleep;  // Sleep seen in the previous cycle.
   } port_reg_t;

endpackage : sram_port_pkg

//--- hdl/sync_burst_sram_port.sv
// What this block does
// RULE_01 - Selected only when enables read low, high, low.
// RULE_02 - Processor strobe start ignores byte write controls.
// RULE_03 - Full write on global, or all lanes.
// RULE_04 - Read bus floats after write until strobe.
// RULE_05 - Master deselects device before asserting sleep.
// RULE_06 - Data pins float on leaving sleep.
// RULE_07 - Burst address steps when advance low.
`timescale 1ns/1ps

module sync_burst_sram_port (
   input wire logic ref_clk,  // System clock, rising edge.
   input wire logic rst,  // Synchronous reset, active high.
   input wire sram_port_pkg::chip_sel_t chip_sel,  // Chip enables.
   input wire logic cpu_addr_strobe_n,  // Processor address strobe.
   input wire logic ctrl_addr_strobe_n,  // Controller address strobe.
   input wire logic burst_step_n,  // Burst advance, active low.
   input wire sram_port_pkg::write_ctl_t write_ctl,  // Write controls.
   input wire logic sleep_pin,  // Sleep request, active high.
   input wire logic [sram_port_pkg::ADDR_W-1:0] addr,  // Word address.
   input wire logic [sram_port_pkg::DATA_W-1:0] dq_in,  // Data pins in.
   output logic [sram_port_pkg::DATA_W-1:0] dq_out,  // Data pins out.
   output logic dq_oe  // High while the port drives the data pins.
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------

   // Composite chip select; every other enable mix deselects.
   function automatic logic chip_selected(input sram_port_pkg::chip_sel_t cs);
      return !cs.pipe_n && cs.depth_hi && !cs.depth_n;  // RULE_01
   endfunction : chip_selected

   // Lanes written this cycle; global write overrides byte selects.
   function automatic logic [sram_port_pkg::LANES-1:0] lane_mask(
      input sram_port_pkg::write_ctl_t wc);
      if (!wc.global_n) begin
         return '1;  // RULE_03
      end else if (!wc.byte_en_n) begin
         return ~wc.lane_n;  // RULE_03
      end
      return '0;
   endfunction : lane_mask

   // ----------------------------------------------------------------
   // State and array
   // ----------------------------------------------------------------
   sram_port_pkg::port_reg_t st_r;  // Registered state.
   sram_port_pkg::port_reg_t st_nxt;  // Next state.
   logic [sram_port_pkg::DATA_W-1:0] mem [sram_port_pkg::DEPTH];  // Array.
   logic strobe;  // Any address strobe this cycle.
   logic sel;  // Composite select this cycle.
   logic [sram_port_pkg::ADDR_W-1:0] cur_addr;  // Address used this cycle.
   logic [sram_port_pkg::LANES-1:0] wmask;  // Lanes written this cycle.

   // Current address: base with the low bits replaced by base plus offset.
   // A strobe cycle uses the pin address directly.
   always_comb begin
      strobe = !cpu_addr_strobe_n || !ctrl_addr_strobe_n;
      sel = chip_selected(chip_sel);
      if (strobe) begin
         cur_addr = addr;
      end else begin
         cur_addr = {st_r.base[sram_port_pkg::ADDR_W-1:sram_port_pkg::BURST_W],
                     st_r.base[sram_port_pkg::BURST_W-1:0] + st_r.cnt};  // RULE_07
      end
   end

   // Write lanes: none in the first cycle of a processor-strobed start.
   // This keeps a processor strobe a pure read start, as the bus expects.
   always_comb begin
      wmask = '0;
      if (sel && !sleep_pin && !cpu_addr_strobe_n) begin
         wmask = '0;  // RULE_02
      end else if (sel && !sleep_pin && (st_r.state != sram_port_pkg::ST_IDLE || strobe)) begin
         wmask = lane_mask(write_ctl);  // RULE_03
      end
   end

   // Array write, lane by lane. The array has no reset, like real cells.
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < sram_port_pkg::LANES; i++) begin
         if (wmask[i]) begin
            mem[cur_addr][i*8 +: 8] <= dq_in[i*8 +: 8];
         end
      end
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.first = 1'b0;
      st_nxt.in_sleep = sleep_pin;
      if (sleep_pin) begin
         // Sleep: the master has deselected first; float and go idle.
         st_nxt.state = sram_port_pkg::ST_IDLE;  // RULE_05
         st_nxt.drive = 1'b0;
      end else if (st_r.in_sleep) begin
         // Leaving sleep never revives an old read value.
         st_nxt.state = sram_port_pkg::ST_IDLE;
         st_nxt.drive = 1'b0;  // RULE_06
      end else if (strobe) begin
         st_nxt.base = addr;
         st_nxt.cnt = sram_port_pkg::BURST_ZERO;
         st_nxt.first = !cpu_addr_strobe_n;
         if (!sel) begin
            st_nxt.state = sram_port_pkg::ST_IDLE;  // RULE_01
            st_nxt.drive = 1'b0;
         end else if (wmask != '0) begin
            st_nxt.state = sram_port_pkg::ST_WRITE;
            st_nxt.drive = 1'b0;
         end else begin
            // A new strobe is the only way back to a driven bus.
            st_nxt.state = sram_port_pkg::ST_READ;  // RULE_04
            st_nxt.drive = 1'b1;
            st_nxt.q = mem[cur_addr];
         end
      end else begin
         unique case (st_r.state)
            sram_port_pkg::ST_IDLE: begin
               st_nxt.drive = 1'b0;
            end
            sram_port_pkg::ST_READ: begin
               if (!burst_step_n) begin
                  st_nxt.cnt = st_r.cnt + sram_port_pkg::BURST_STEP;  // RULE_07
               end
               if (wmask != '0) begin
                  // A write inside a read burst floats the bus until a strobe.
                  st_nxt.state = sram_port_pkg::ST_WRITE;  // RULE_04
                  st_nxt.drive = 1'b0;
               end else begin
                  st_nxt.q = mem[cur_addr];
               end
            end
            sram_port_pkg::ST_WRITE: begin
               if (!burst_step_n) begin
                  st_nxt.cnt = st_r.cnt + sram_port_pkg::BURST_STEP;  // RULE_07
               end
               st_nxt.drive = 1'b0;  // RULE_04
            end
            default: begin
               // An illegal code, such as the unknown one before the first reset,
               // falls back to idle with the bus floated.
               st_nxt.state = sram_port_pkg::ST_IDLE;
               st_nxt.drive = 1'b0;
            end
         endcase
      end
   end

   // State register.
   // The reset is a convenience for the system; the array keeps its contents.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= '{state: sram_port_pkg::ST_IDLE, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   // Both pins come straight from flip-flops, so the enable never glitches.
   assign dq_out = st_r.q;
   assign dq_oe = st_r.drive;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // The bus and burst checks look one edge past their cause; the write-mask and first-cycle checks look in the same cycle.
   // They are off while the reset holds, since the state is not yet known then.
   a_desel_float: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
      (strobe && !sel && !sleep_pin && !st_r.in_sleep) |=> !dq_oe)
      else $error("Deselected strobe left the bus driven.");

   a_cpu_no_write: assert property (@(posedge ref_clk) disable iff (rst) // RULE_02
      !cpu_addr_strobe_n |-> wmask == '0)
      else $error("Write on a processor-strobed first cycle.");

   a_global_full: assert property (@(posedge ref_clk) disable iff (rst) // RULE_03
      (sel && !sleep_pin && cpu_addr_strobe_n && !ctrl_addr_strobe_n && !write_ctl.global_n)
      |-> wmask == '1)
      else $error("Global write did not write every lane.");

   a_write_float: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
      (st_r.state == sram_port_pkg::ST_WRITE && !strobe) |=> !dq_oe)
      else $error("Bus driven after write without a strobe.");

   a_sleep_float: assert property (@(posedge ref_clk) disable iff (rst) // RULE_05
      sleep_pin |=> !dq_oe)
      else $error("Bus driven during sleep.");

   a_wake_float: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
      $fell(sleep_pin) |=> !dq_oe)
      else $error("Bus driven on leaving sleep.");

   a_burst_step: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
      (!strobe && !sleep_pin && !st_r.in_sleep && st_r.state != sram_port_pkg::ST_IDLE)
      |=> st_r.cnt == $past(st_r.cnt) + {1'b0, !$past(burst_step_n)})
      else $error("Burst counter did not follow advance.");

   a_read_drive: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
      (strobe && sel && !sleep_pin && !st_r.in_sleep && wmask == '0) |=> dq_oe)
      else $error("Read strobe did not drive the bus.");

   a_lanes_full: assert property (@(posedge ref_clk) disable iff (rst) // RULE_03
      (sel && !sleep_pin && cpu_addr_strobe_n && !ctrl_addr_strobe_n && write_ctl.global_n
       && !write_ctl.byte_en_n && write_ctl.lane_n == '0) |-> wmask == '1)
      else $error("Byte write with all lanes did not write every lane.");

   a_wake_idle: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
      (st_r.in_sleep && !sleep_pin) |=> (!dq_oe && st_r.state == sram_port_pkg::ST_IDLE))
      else $error("Port left idle in the first cycle after sleep.");

   a_first_read: assert property (@(posedge ref_clk) disable iff (rst) // RULE_02
      st_r.first |-> (!$past(cpu_addr_strobe_n) && st_r.state != sram_port_pkg::ST_WRITE))
      else $error("Processor-strobed start led to a write burst.");

endmodule : sync_burst_sram_port

//--- bench/sram_master_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Bus master model
// ---------------------------------------------------------------
module sram_master_model (
   input wire logic ref_clk, // Clock.
   output sram_port_pkg::chip_sel_t chip_sel, // Chip enables.
   output logic cpu_addr_strobe_n, // Processor strobe.
   output logic ctrl_addr_strobe_n, // Controller strobe.
   output logic burst_step_n, // Burst advance.
   output sram_port_pkg::write_ctl_t write_ctl, // Write controls.
   output logic sleep_pin, // Sleep request.
   output logic [7:0] addr, // Word address.
   output logic [31:0] dq_in // Write data.
);
   // The bus starts deselected and idle.
   initial begin
      chip_sel = 3'h6;
      {cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, sleep_pin} = 4'hE;
      write_ctl = 6'h3F;
      addr = 8'h00;
      dq_in = 32'h0;
   end

   // One bus cycle, launched off the falling edge; returns after the rising edge.
   task cyc(input sram_port_pkg::chip_sel_t cs, input logic cpu, ctrl, step,
            input sram_port_pkg::write_ctl_t wc, input logic slp,
            input logic [7:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      chip_sel <= cs;
      cpu_addr_strobe_n <= cpu;
      ctrl_addr_strobe_n <= ctrl;
      burst_step_n <= step;
      write_ctl <= wc;
      sleep_pin <= slp;
      addr <= a;
      // Data is not held when no write is asked, so stale values cannot pass.
      dq_in <= (wc == 6'h3F) ? ~dq_in : d;
      @(posedge ref_clk);
      #1;
   endtask : cyc

   // Sleep for n cycles, then wake with a read strobe that the port must refuse.
   task nap(input int n);
      cyc(3'h6, 1'b1, 1'b0, 1'b1, 6'h3F, 1'b0, 8'h00, 32'h0);
      repeat (n) cyc(3'h6, 1'b1, 1'b1, 1'b1, 6'h3F, 1'b1, 8'h00, 32'h0);
      cyc(3'h2, 1'b0, 1'b1, 1'b1, 6'h3F, 1'b0, 8'h05, 32'h0);
   endtask : nap
endmodule : sram_master_model

//--- bench/sync_burst_sram_port_tb.sv
`timescale 1ns/1ps

module sync_burst_sram_port_tb;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic ref_clk = 1'b0; // 50 MHz clock.
   logic rst = 1'b1; // Synchronous reset.
   sram_port_pkg::chip_sel_t chip_sel; // Chip enables.
   logic cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, sleep_pin; // Controls.
   sram_port_pkg::write_ctl_t write_ctl; // Write controls.
   logic [7:0] addr, a; // Bus address and scratch address.
   logic [31:0] dq_in, dq_out; // Data pins.
   logic dq_oe, st; // Output enable and scratch advance.
   logic [1:0] off; // Expected burst offset.
   logic [31:0] ref_mem [256]; // Expected array contents.
   int failures = 0, tests_run = 0, cycles = 0, seed = 71;

   always #10 ref_clk = ~ref_clk;

   sync_burst_sram_port sync_burst_sram_port_inst (.ref_clk, .rst, .chip_sel,
      .cpu_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n, .write_ctl,
      .sleep_pin, .addr, .dq_in, .dq_out, .dq_oe);
   sram_master_model m (.ref_clk, .chip_sel, .cpu_addr_strobe_n, .ctrl_addr_strobe_n,
      .burst_step_n, .write_ctl, .sleep_pin, .addr, .dq_in);

   // ---------------------------------------------------------------
   // Expectation and checking
   // ---------------------------------------------------------------
   // New word after a controller-strobed cycle with these controls.
   function automatic logic [31:0] merge(logic [31:0] old, d,
         sram_port_pkg::write_ctl_t wc, sram_port_pkg::chip_sel_t cs);
      logic [31:0] r;
      r = old;
      if (cs !== 3'h2) return old;
      if (!wc.global_n) return d;
      if (!wc.byte_en_n) for (int i = 0; i < 4; i++) if (!wc.lane_n[i]) r[8*i +: 8] = d[8*i +: 8];
      return r;
   endfunction : merge

   // Bus drive after a controller strobe: a selected strobe that writes no lane is a read.
   function automatic logic ctrl_drive(sram_port_pkg::write_ctl_t wc,
         sram_port_pkg::chip_sel_t cs);
      return (cs === 3'h2) && wc.global_n && (wc.byte_en_n || wc.lane_n === 4'hF);
   endfunction : ctrl_drive

   task automatic chk_data(string n, logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk_data

   task automatic chk_flag(string n, logic e, g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask : chk_flag

   // Controller-strobed access; the bus floats after a write and drives after a read.
   task automatic wr(logic [7:0] wa, logic [31:0] d, sram_port_pkg::write_ctl_t wc,
         sram_port_pkg::chip_sel_t cs);
      m.cyc(cs, 1'b1, 1'b0, 1'b1, wc, 1'b0, wa, d);
      ref_mem[wa] = merge(ref_mem[wa], d, wc, cs);
      chk_flag("oe_after_write", ctrl_drive(wc, cs), dq_oe);
      if (ctrl_drive(wc, cs)) chk_data("ctrl_read", ref_mem[wa], dq_out);
   endtask : wr

   // Processor-strobed read with random write controls, which must be ignored.
   task automatic rd(logic [7:0] ra);
      m.cyc(3'h2, 1'b0, 1'b1, 1'b1, 6'($random(seed)), 1'b0, ra, $random(seed));
      chk_flag("oe_read", 1'b1, dq_oe);
      chk_data("read_data", ref_mem[ra], dq_out);
   endtask : rd

   task end_of_test;
      if (failures == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   // A hang is cut short well beyond the few hundred cycles needed.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         end_of_test();
      end
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk) rst <= 1'b0;
      @(posedge ref_clk) #1 chk_flag("oe_reset", 1'b0, dq_oe);
      // Fill the whole array, alternating the two full-width write forms.
      for (int i = 0; i < 256; i++) wr(8'(i), $random(seed), i[0] ? 6'h20 : 6'h1F, 3'h2);
      // Random controls; every other write is selected, the rest get random enables.
      for (int k = 0; k < 60; k++) begin
         a = 8'($random(seed));
         wr(a, $random(seed), 6'($random(seed)), k[0] ? 3'h2 : 3'($random(seed)));
         rd(a);
      end
      // The bus stays floated past an idle cycle after a write.
      wr(8'h10, $random(seed), 6'h1F, 3'h2);
      m.cyc(3'h2, 1'b1, 1'b1, 1'b1, 6'h3F, 1'b0, 8'h00, 32'h0);
      chk_flag("oe_hold", 1'b0, dq_oe);
      // Two advancing write cycles inside the burst fill offsets 0 and 1.
      for (int i = 0; i < 2; i++) begin
         a = 8'($random(seed));
         m.cyc(3'h2, 1'b1, 1'b1, 1'b0, 6'h1F, 1'b0, 8'h00, {4{a}});
         ref_mem[8'h10 + 8'(i)] = {4{a}};
         chk_flag("oe_burst_write", 1'b0, dq_oe);
      end
      rd(8'h11);
      // Burst from offset 2, wrapping inside the group of four.
      rd(8'h42);
      off = 2'h2;
      for (int i = 0; i < 8; i++) begin
         st = 1'($random(seed));
         m.cyc(3'h2, 1'b1, 1'b1, st, 6'h3F, 1'b0, 8'h00, 32'h0);
         // The word read at an advance edge is the one before the step.
         chk_data("burst_data", ref_mem[{6'h10, off}], dq_out);
         if (!st) off++;
      end
      // Start a read, then deselect and sleep; it must wake floated.
      rd(8'h05);
      m.nap(3);
      chk_flag("oe_wake", 1'b0, dq_oe);
      rd(8'h05);
      end_of_test();
   end
endmodule : sync_burst_sram_port_tb
